// *** verilog/fpu_exc_pkg.sv ***
// shared constants, types and decode helpers of the floating-point exception unit
package fpu_exc_pkg;

	// ==========================================================
	// register map (byte addresses) and reset values
	localparam logic [7:0]  REG_CTRL    = 8'h00;
	localparam logic [7:0]  REG_STATUS  = 8'h04;
	localparam logic [7:0]  REG_TAGS    = 8'h08;
	localparam logic [7:0]  REG_OPER    = 8'h0C;
	localparam logic [7:0]  REG_RESULT  = 8'h10;
	localparam logic [7:0]  REG_PFLAGS  = 8'h14;
	localparam logic [15:0] CTRL_RST    = 16'h0003;
	localparam logic [15:0] CTRL_WMASK  = 16'h0003;
	localparam logic [15:0] STATUS_RST  = 16'h0000;
	localparam logic [15:0] STATUS_WMASK = 16'h7F43;
	localparam logic [15:0] TAGS_RST    = 16'hFFFF;

	// ==========================================================
	// field positions
	localparam int CW_IM_BIT   = 0;
	localparam int CW_DM_BIT   = 1;
	localparam int ST_IE_BIT   = 0;
	localparam int ST_DE_BIT   = 1;
	localparam int ST_SF_BIT   = 6;
	localparam int ST_CC0_BIT  = 8;
	localparam int ST_CC1_BIT  = 9;
	localparam int ST_CC2_BIT  = 10;
	localparam int ST_TOP_LSB  = 11;
	localparam int ST_CC3_BIT  = 14;
	localparam int RES_TRAP_BIT = 3;
	localparam int RES_BUSY_BIT = 4;
	localparam int PF_CARRY_BIT  = 0;
	localparam int PF_PARITY_BIT = 1;
	localparam int PF_ZERO_BIT   = 2;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		TAG_VALID   = 2'h0,
		TAG_ZERO    = 2'h1,
		TAG_SPECIAL = 2'h2,
		TAG_EMPTY   = 2'h3
	} tag_t;

	typedef enum logic [2:0] {
		CLS_ZERO = 3'h0, CLS_NORMAL = 3'h1, CLS_DENORM = 3'h2, CLS_INF = 3'h3,
		CLS_QNAN = 3'h4, CLS_SNAN = 3'h5, CLS_UNSUP = 3'h6
	} cls_t;

	typedef enum logic [4:0] {
		OP_LOAD_SD = 5'h00, OP_LOAD_EXT, OP_STORE_FP, OP_STORE_INT, OP_STORE_BCD,
		OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_COMPARE, OP_COMPARE_FLAGS, OP_UCOMPARE,
		OP_REMAINDER, OP_TRIG, OP_SQRT, OP_LOG, OP_LOG_P1, OP_EXCHANGE
	} op_t;

	typedef enum logic [2:0] {
		RES_PROCEED = 3'h0, RES_FP_INDEF = 3'h1, RES_INT_INDEF = 3'h2,
		RES_BCD_INDEF = 3'h3, RES_QNAN_SRC = 3'h4, RES_NONE = 3'h5
	} res_t;

	// command word, bit 0 is the lsb of op
	typedef struct packed {
		logic       below_m1;
		logic       out_of_range;
		logic       sgn_b;
		cls_t       cls_b;
		logic       sgn_a;
		cls_t       cls_a;
		logic [2:0] reg_b;
		op_t        op;
	} cmd_t;

	localparam int CMD_W = $bits(cmd_t);

	typedef struct packed {
		logic ia;
		logic unordered;
		logic cc2_clr;
		res_t kind;
	} verdict_t;

	// ==========================================================
	// decode helpers
	function automatic logic [1:0] src_count(input op_t op);
		case (op)
			OP_LOAD_SD, OP_LOAD_EXT:                        src_count = 2'd0;
			OP_STORE_FP, OP_STORE_INT, OP_STORE_BCD,
			OP_TRIG, OP_SQRT, OP_LOG_P1:                    src_count = 2'd1;
			default:                                        src_count = 2'd2;
		endcase
	endfunction : src_count

	function automatic logic is_nan(input cls_t c);
		is_nan = (c == CLS_QNAN) || (c == CLS_SNAN);
	endfunction : is_nan

endpackage : fpu_exc_pkg

// *** verilog/fpu_tag_file.sv ***
// eight two-bit register tags with registered read ports and two write ports
`timescale 1ns/1ns
module fpu_tag_file import fpu_exc_pkg::*; (
	input  logic        clk,      // core clock
	input  logic        rst_n,    // synchronous reset, active low
	input  logic        bulk_we,  // load all tags at once
	input  logic [15:0] bulk_d,   // tag word, entry i at bits 2i+1:2i
	input  logic        we_a,     // write port a
	input  logic [2:0]  wa_a,     // write address a
	input  tag_t        wd_a,     // write data a
	input  logic        we_b,     // write port b, wins over a on same entry
	input  logic [2:0]  wa_b,     // write address b
	input  tag_t        wd_b,     // write data b
	input  logic [2:0]  ra_a,     // read address a
	input  logic [2:0]  ra_b,     // read address b
	output tag_t        rd_a,     // registered read data a
	output tag_t        rd_b,     // registered read data b
	output logic [15:0] all_q     // whole tag word
);

	logic [15:0] tags_ff;

	assign all_q = tags_ff;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			tags_ff <= TAGS_RST;
		else if (bulk_we)
			tags_ff <= bulk_d;
		else
		begin
			if (we_a)
				tags_ff[wa_a*2 +: 2] <= wd_a;
			if (we_b)
				tags_ff[wa_b*2 +: 2] <= wd_b;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rd_a <= TAG_EMPTY;
			rd_b <= TAG_EMPTY;
		end
		else
		begin
			rd_a <= tag_t'(tags_ff[ra_a*2 +: 2]);
			rd_b <= tag_t'(tags_ff[ra_b*2 +: 2]);
		end
	end

endmodule : fpu_tag_file

// *** verilog/fpu_invalid_detect.sv ***
// operand checks that raise the invalid-arithmetic-operand condition
`timescale 1ns/1ns
module fpu_invalid_detect import fpu_exc_pkg::*; (
	input  cmd_t     cmd,     // operation and operand classes
	output verdict_t verdict  // condition and masked response
);

	logic two;
	logic a_nan;
	logic b_nan;
	logic any_snan;
	logic any_unsup;
	logic both_inf;
	logic bad;

	always_comb
	begin
		two       = (src_count(cmd.op) == 2'd2);
		a_nan     = is_nan(cmd.cls_a);
		b_nan     = two && is_nan(cmd.cls_b);
		any_snan  = (cmd.cls_a == CLS_SNAN) || (two && cmd.cls_b == CLS_SNAN);
		any_unsup = (cmd.cls_a == CLS_UNSUP) || (two && cmd.cls_b == CLS_UNSUP);
		both_inf  = (cmd.cls_a == CLS_INF) && (cmd.cls_b == CLS_INF);
		bad       = 1'b0;
		verdict   = '0;
		verdict.kind = RES_PROCEED;
		case (cmd.op)
			OP_LOAD_EXT, OP_EXCHANGE: ;
			OP_STORE_INT, OP_STORE_BCD:
				if (a_nan || cmd.cls_a == CLS_INF || cmd.cls_a == CLS_UNSUP
					|| cmd.out_of_range)
				begin
					verdict.ia   = 1'b1;
					verdict.kind = (cmd.op == OP_STORE_INT) ? RES_INT_INDEF : RES_BCD_INDEF;
				end
			OP_COMPARE, OP_COMPARE_FLAGS:
				if (a_nan || b_nan || any_unsup)
				begin
					verdict.ia        = 1'b1;
					verdict.unordered = 1'b1;
					verdict.kind      = RES_NONE;
				end
			OP_UCOMPARE:
			begin
				// quiet nans only make the result unordered, they do not fault
				verdict.ia        = any_snan || any_unsup;
				verdict.unordered = a_nan || b_nan || any_unsup;
				verdict.kind      = RES_NONE;
			end
			default:
			begin
				if (any_unsup)
				begin
					verdict.ia   = 1'b1;
					verdict.kind = RES_FP_INDEF;
				end
				else if (any_snan)
				begin
					verdict.ia   = 1'b1;
					verdict.kind = RES_QNAN_SRC;
				end
				else if (!(a_nan || b_nan))
				begin
					case (cmd.op)
						OP_ADD:  bad = both_inf && (cmd.sgn_a != cmd.sgn_b);
						OP_SUB:  bad = both_inf && (cmd.sgn_a == cmd.sgn_b);
						OP_MUL:  bad = (cmd.cls_a == CLS_INF && cmd.cls_b == CLS_ZERO)
							|| (cmd.cls_a == CLS_ZERO && cmd.cls_b == CLS_INF);
						OP_DIV:  bad = both_inf
							|| (cmd.cls_a == CLS_ZERO && cmd.cls_b == CLS_ZERO);
						OP_REMAINDER: bad = (cmd.cls_b == CLS_ZERO) || (cmd.cls_a == CLS_INF);
						OP_TRIG: bad = (cmd.cls_a == CLS_INF);
						OP_SQRT, OP_LOG: bad = cmd.sgn_a && (cmd.cls_a != CLS_ZERO);
						OP_LOG_P1: bad = cmd.below_m1;
						default: bad = 1'b0;
					endcase
					verdict.ia      = bad;
					verdict.cc2_clr = bad && (cmd.op == OP_REMAINDER || cmd.op == OP_TRIG);
					verdict.kind    = bad ? RES_FP_INDEF : RES_PROCEED;
				end
			end
		endcase
	end

endmodule : fpu_invalid_detect

// *** verilog/fpu_exc_unit.sv ***
// invalid-operation and denormal-operand exception unit with apb registers
// ==========================================================
// Functional notes
// - invalid flag is status bit 0, its mask is control bit 0.
// - stack fault flag 1 means stack fault, 0 means invalid operand.
// - stack fault flag is set on stack faults, never cleared by operand faults.
// - overflow when a memory load targets a register not tagged empty.
// - underflow when a source register, including a stored one, is tagged empty.
// - stack fault sets invalid flag and stack fault flag (bit 6).
// - stack fault sets condition code one: 1 overflow, 0 underflow.
// - masked stack fault writes fp, integer or decimal indefinite to destination.
// - unmasked invalid calls the handler, top and sources stay unchanged.
// - invalid operand sets invalid flag; masked gives indefinite, nan or codes.
// - masked unsupported operand gives indefinite, signaling nan gives quiet nan.
// - masked ordered compare with nan sets codes or processor flags to 111.
// - masked infinity/zero misuse in add, sub, mul, div gives indefinite.
// - masked bad remainder or trig source gives indefinite and clears code two.
// - masked negative root, negative log, log-plus-one below -1 give indefinite.
// - masked decimal store of unrepresentable or special source writes decimal indefinite.
// - masked integer store out of range or special source writes integer indefinite.
// - masked exchange fills empty registers with indefinite, then exchanges.
// - quiet nan faults only in ordered compares and integer or decimal stores.
// - denormal raised by arithmetic on denormal or single/double denormal load.
// - denormal flag is status bit 1, its mask is control bit 1.
// - masked denormal sets flag and proceeds; unmasked sets flag and calls handler.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
module fpu_exc_unit import fpu_exc_pkg::*; (
	input  logic        CLK_SYS,      // core clock, 100 MHz
	input  logic        RESETN,       // synchronous reset, active low
	input  logic        PSEL,         // apb select
	input  logic        PENABLE,      // apb access phase
	input  logic        PWRITE,       // apb direction, high for write
	input  logic [7:0]  PADDR,        // apb byte address
	input  logic [31:0] PWDATA,       // apb write data
	output logic [31:0] PRDATA,       // apb read data
	output logic        PREADY,       // apb ready
	output logic        PSLVERR,      // apb error
	output logic        HANDLER_REQ   // one-cycle request for the software handler
);

	// ==========================================================
	// declarations
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_READ   = 3'b010,
		ST_COMMIT = 3'b100
	} state_t;

	state_t      state_ff;
	state_t      nxt_state;
	logic [15:0] ctrl_ff;
	logic [15:0] status_ff;
	logic [15:0] nxt_status;
	logic [2:0]  pflags_ff;
	logic [2:0]  nxt_pflags;
	cmd_t        cmd_ff;
	res_t        res_ff;
	res_t        nxt_res;
	logic        trap_ff;
	logic        handler_ff;
	logic [31:0] prdata_ff;

	logic        access;
	logic        addr_ok;
	logic        busy;
	logic        err;
	logic        wr;
	logic [2:0]  top;
	logic [2:0]  ra_a;
	logic [2:0]  ra_b;
	tag_t        td_a;
	tag_t        td_b;
	logic [15:0] tag_word;
	verdict_t    verdict;

	logic        is_load;
	logic [1:0]  nsrc;
	logic        ovf;
	logic        unf;
	logic        sf_evt;
	logic        inv_evt;
	logic        den_evt;
	logic        trap;
	logic        unordered;
	logic        we_a;
	logic        we_b;
	tag_t        wd_a;
	tag_t        wd_b;

	// ==========================================================
	// apb slave: zero wait states, read data registered in the setup cycle
	always_comb
	begin
		case (PADDR)
			REG_CTRL, REG_STATUS, REG_TAGS, REG_OPER, REG_RESULT, REG_PFLAGS:
				addr_ok = 1'b1;
			default:
				addr_ok = 1'b0;
		endcase
	end

	assign access  = PSEL && PENABLE;
	assign busy    = (state_ff != ST_IDLE);
	// writes are refused while an operation is in flight, so that a software
	// clear can never collide with a flag being raised by the same operation
	assign err     = access && (!addr_ok
		|| (PWRITE && (busy || PADDR == REG_RESULT)));
	assign wr      = access && PWRITE && !err;
	assign PREADY  = 1'b1;
	assign PSLVERR = err;
	assign PRDATA  = prdata_ff;
	assign HANDLER_REQ = handler_ff;

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			prdata_ff <= 32'h0000_0000;
		else if (PSEL && !PENABLE && !PWRITE)
		begin
			case (PADDR)
				REG_CTRL:   prdata_ff <= {16'h0000, ctrl_ff};
				REG_STATUS: prdata_ff <= {16'h0000, status_ff};
				REG_TAGS:   prdata_ff <= {16'h0000, tag_word};
				REG_OPER:   prdata_ff <= 32'(cmd_ff);
				REG_RESULT: prdata_ff <= 32'({busy, trap_ff, res_ff});
				REG_PFLAGS: prdata_ff <= {29'h0000_0000, pflags_ff};
				default:    prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			ctrl_ff <= CTRL_RST;
		else if (wr && PADDR == REG_CTRL)
			ctrl_ff <= PWDATA[15:0] & CTRL_WMASK;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			cmd_ff <= '0;
		else if (wr && PADDR == REG_OPER)
			cmd_ff <= cmd_t'(PWDATA[CMD_W-1:0]);
	end

	// ==========================================================
	// sequencing: latch command, read tags, commit
	always_comb
	begin
		case (state_ff)
			ST_IDLE:   nxt_state = (wr && PADDR == REG_OPER) ? ST_READ : ST_IDLE;
			ST_READ:   nxt_state = ST_COMMIT;
			ST_COMMIT: nxt_state = ST_IDLE;
			default:   nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// ==========================================================
	// tag storage
	assign top     = status_ff[ST_TOP_LSB +: 3];
	assign is_load = (cmd_ff.op == OP_LOAD_SD) || (cmd_ff.op == OP_LOAD_EXT);
	assign nsrc    = src_count(cmd_ff.op);
	// a load pushes, so its target is the register just below the top
	assign ra_a    = is_load ? 3'(top - 3'd1) : top;
	assign ra_b    = 3'(top + cmd_ff.reg_b);

	fpu_tag_file u_tags (
		.clk     (CLK_SYS),
		.rst_n   (RESETN),
		.bulk_we (wr && PADDR == REG_TAGS),
		.bulk_d  (PWDATA[15:0]),
		.we_a    (we_a),
		.wa_a    (ra_a),
		.wd_a    (wd_a),
		.we_b    (we_b),
		.wa_b    (ra_b),
		.wd_b    (wd_b),
		.ra_a    (ra_a),
		.ra_b    (ra_b),
		.rd_a    (td_a),
		.rd_b    (td_b),
		.all_q   (tag_word)
	);

	fpu_invalid_detect u_inv (
		.cmd     (cmd_ff),
		.verdict (verdict)
	);

	// ==========================================================
	// exception evaluation, acts only in the commit cycle
	always_comb
	begin
		ovf = is_load && (td_a != TAG_EMPTY);
		unf = !is_load && (((nsrc != 2'd0) && td_a == TAG_EMPTY)
			|| ((nsrc == 2'd2) && td_b == TAG_EMPTY));
		sf_evt  = ovf || unf;
		// a stack fault hides any operand condition of the same operation
		inv_evt = sf_evt || verdict.ia;
		den_evt = !inv_evt && (
			(cmd_ff.op == OP_LOAD_SD && cmd_ff.cls_a == CLS_DENORM)
			|| (!is_load && cmd_ff.op != OP_EXCHANGE && (cmd_ff.cls_a == CLS_DENORM
			|| (nsrc == 2'd2 && cmd_ff.cls_b == CLS_DENORM))));
		trap = (inv_evt && !ctrl_ff[CW_IM_BIT])
			|| (den_evt && !ctrl_ff[CW_DM_BIT]);
		unordered = verdict.unordered
			|| (sf_evt && (cmd_ff.op == OP_COMPARE || cmd_ff.op == OP_UCOMPARE
			|| cmd_ff.op == OP_COMPARE_FLAGS));

		nxt_status = status_ff;
		nxt_pflags = pflags_ff;
		nxt_res    = RES_PROCEED;
		we_a       = 1'b0;
		we_b       = 1'b0;
		wd_a       = TAG_SPECIAL;
		wd_b       = TAG_SPECIAL;

		// flags only ever get set here, software clears them
		if (inv_evt)
			nxt_status[ST_IE_BIT] = 1'b1;
		if (den_evt)
			nxt_status[ST_DE_BIT] = 1'b1;
		if (sf_evt)
		begin
			nxt_status[ST_SF_BIT]  = 1'b1;
			nxt_status[ST_CC1_BIT] = ovf;
		end

		if (trap)
			nxt_res = RES_NONE;
		else
		begin
			if (sf_evt)
			begin
				case (cmd_ff.op)
					OP_STORE_INT: nxt_res = RES_INT_INDEF;
					OP_STORE_BCD: nxt_res = RES_BCD_INDEF;
					OP_COMPARE, OP_UCOMPARE, OP_COMPARE_FLAGS: nxt_res = RES_NONE;
					OP_EXCHANGE: nxt_res = RES_PROCEED;
					default:      nxt_res = RES_FP_INDEF;
				endcase
			end
			else if (verdict.ia || unordered)
				nxt_res = verdict.kind;
			if (unordered)
			begin
				if (cmd_ff.op == OP_COMPARE_FLAGS)
					nxt_pflags = 3'h7;
				else
				begin
					nxt_status[ST_CC0_BIT] = 1'b1;
					nxt_status[ST_CC2_BIT] = 1'b1;
					nxt_status[ST_CC3_BIT] = 1'b1;
				end
			end
			if (verdict.cc2_clr && !sf_evt)
				nxt_status[ST_CC2_BIT] = 1'b0;

			// stack effects happen only when no handler is called
			if (is_load)
			begin
				nxt_status[ST_TOP_LSB +: 3] = 3'(top - 3'd1);
				we_a = 1'b1;
				if (ovf)
					wd_a = TAG_SPECIAL;
				else if (cmd_ff.cls_a == CLS_ZERO)
					wd_a = TAG_ZERO;
				else if (cmd_ff.cls_a == CLS_NORMAL
					|| (cmd_ff.op == OP_LOAD_SD && cmd_ff.cls_a == CLS_DENORM))
					wd_a = TAG_VALID;
				else
					wd_a = TAG_SPECIAL;
			end
			else if (cmd_ff.op == OP_EXCHANGE)
			begin
				// an empty side is first filled with indefinite, then tags swap
				we_a = 1'b1;
				we_b = 1'b1;
				wd_a = (td_b == TAG_EMPTY) ? TAG_SPECIAL : td_b;
				wd_b = (td_a == TAG_EMPTY) ? TAG_SPECIAL : td_a;
			end
			else if (nxt_res != RES_PROCEED && nxt_res != RES_NONE
				&& cmd_ff.op != OP_STORE_FP && cmd_ff.op != OP_STORE_INT
				&& cmd_ff.op != OP_STORE_BCD)
			begin
				we_a = 1'b1;
				wd_a = TAG_SPECIAL;
			end
		end

		if (state_ff != ST_COMMIT)
		begin
			we_a = 1'b0;
			we_b = 1'b0;
		end
	end

	// ==========================================================
	// architectural state
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			status_ff <= STATUS_RST;
		else if (wr && PADDR == REG_STATUS)
			// flag bits clear where a one is written, codes and top load directly
			status_ff <= (PWDATA[15:0] & STATUS_WMASK & 16'hFFBC)
				| (status_ff & 16'h0043 & ~PWDATA[15:0]);
		else if (state_ff == ST_COMMIT)
			status_ff <= nxt_status;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			pflags_ff <= 3'h0;
		else if (wr && PADDR == REG_PFLAGS)
			pflags_ff <= PWDATA[2:0];
		else if (state_ff == ST_COMMIT)
			pflags_ff <= nxt_pflags;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
		begin
			res_ff     <= RES_PROCEED;
			trap_ff    <= 1'b0;
			handler_ff <= 1'b0;
		end
		else
		begin
			handler_ff <= (state_ff == ST_COMMIT) && trap;
			if (state_ff == ST_COMMIT)
			begin
				res_ff  <= nxt_res;
				trap_ff <= trap;
			end
		end
	end

endmodule : fpu_exc_unit

// *** verification/fpu_exc_unit_props.sv ***
// checker of the exception unit bus and handler request
`timescale 1ns/1ns
module fpu_exc_unit_props (
	input wire logic        CLK_SYS,     // core clock
	input wire logic        RESETN,      // reset, active low
	input wire logic        PSEL,        // apb select
	input wire logic        PENABLE,     // apb access
	input wire logic        PWRITE,      // apb direction
	input wire logic [7:0]  PADDR,       // apb address
	input wire logic [31:0] PWDATA,      // apb write data
	input wire logic [31:0] PRDATA,      // apb read data
	input wire logic        PREADY,      // apb ready
	input wire logic        PSLVERR,     // apb error
	input wire logic        HANDLER_REQ  // handler request
);
	// ==========================================================
	// helpers
	logic       acc;
	logic       mapped;
	logic       oper_wr;
	logic [1:0] ctrl_ff;
	assign acc     = PSEL && PENABLE;
	assign mapped  = (PADDR[1:0] == 2'h0) && (PADDR <= 8'h14);
	assign oper_wr = acc && PWRITE && (PADDR == 8'h0C) && !PSLVERR;
	// mask shadow tells a masked launch from a trap
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			ctrl_ff <= 2'h3;
		else if (acc && PWRITE && (PADDR == 8'h00) && !PSLVERR)
			ctrl_ff <= PWDATA[1:0];
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	a_ready_each_access: assert property (acc |-> PREADY)
		else $error("ready low");
	a_handler_one_cycle: assert property (HANDLER_REQ |=> !HANDLER_REQ)
		else $error("handler request too long");
	a_handler_has_cause: assert property (HANDLER_REQ |-> $past(oper_wr, 3))
		else $error("handler request without launch");
	a_masked_no_trap: assert property (oper_wr && ctrl_ff == 2'h3 |-> ##3 !HANDLER_REQ)
		else $error("handler while masked");
	a_ctrl_two_bits: assert property (acc && !PWRITE && PADDR == 8'h00 |-> PRDATA[31:2] == 0)
		else $error("control bits beyond masks");
	a_status_fields: assert property (acc && !PWRITE && PADDR == 8'h04
		|-> (PRDATA & 32'hFFFF_80BC) == 0)
		else $error("status bits outside fields");
	a_unmapped_error: assert property (acc && !mapped |-> PSLVERR && (PWRITE || PRDATA == 0))
		else $error("unmapped not refused");
	a_result_read_only: assert property (acc && PWRITE && PADDR == 8'h10 |-> PSLVERR)
		else $error("result write not refused");
	c_trap: cover property (HANDLER_REQ);
	c_launch: cover property (oper_wr);
	c_refused: cover property (acc && PSLVERR);
endmodule : fpu_exc_unit_props

bind fpu_exc_unit fpu_exc_unit_props props_u (.CLK_SYS, .RESETN, .PSEL, .PENABLE,
	.PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .HANDLER_REQ);

// *** verification/exc_handler_model.sv ***
// handler model: counts handler entries
`timescale 1ns/1ns
module exc_handler_model (
	input wire logic CLK_SYS,     // core clock
	input wire logic RESETN,      // reset, active low
	input wire logic HANDLER_REQ, // request pulse
	output int       calls        // handler entries so far
);
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			calls <= 0;
		else if (HANDLER_REQ)
			calls <= calls + 1;
	end
endmodule : exc_handler_model

// *** verification/fpu_exc_unit_tb_top.sv ***
// bench of the fp exception unit
`timescale 1ns/1ns
module fpu_exc_unit_tb_top import fpu_exc_pkg::*; ;
	logic        clk     = 1'b0;
	logic        resetn  = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        hreq;
	int          calls;
	int          fail_count = 0;
	int          n_checks   = 0;
	int          cycles     = 0;
	always #5 clk = ~clk;
	fpu_exc_unit dut_u (.CLK_SYS(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .HANDLER_REQ(hreq));
	exc_handler_model hmod_u (.CLK_SYS(clk), .RESETN(resetn), .HANDLER_REQ(hreq),
		.calls(calls));
	// ==========================================================
	// bus and compare tasks
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [31:0] x, input logic [31:0] got);
		n_checks++;
		if (got !== x)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, x, got);
		end
	endtask : chk
	// an idle edge follows each transfer
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
		input string what);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(what, x, q & m);
	endtask : rd_chk
	function automatic logic [31:0] mk(op_t o, cls_t ca, logic sa = 1'b0,
		cls_t cb = CLS_NORMAL, logic sb = 1'b0, logic oor = 1'b0, logic bm = 1'b0);
		cmd_t c;
		c = {bm, oor, sb, cb, sa, ca, 3'h1, o};
		return {14'h0, c};
	endfunction : mk
	// returns right after the commit edge
	task automatic op(input logic [31:0] c);
		wr(REG_OPER, c);
		@(posedge clk);
	endtask : op
	// preset inverts expected cc1, keeps sf unless cc1 is judged
	task automatic ia(input logic [31:0] c, input logic [2:0] k, input logic [15:0] m,
		input logic [15:0] x);
		logic [15:0] p;
		p = 16'h0401 | (~x & 16'h0200) | (m[9] ? 16'h0040 : 16'h0000);
		wr(REG_STATUS, {16'h0, p});
		op(c);
		rd_chk(REG_STATUS, {16'h0, m}, {16'h0, x}, "status");
		if (k != 3'h7)
			rd_chk(REG_RESULT, 32'h0000_0007, {29'h0, k}, "result kind");
	endtask : ia
	// ==========================================================
	// scenarios
	task automatic t_reset();
		logic [31:0] q;
		logic        e;
		rd_chk(REG_CTRL, '1, 32'h0000_0003, "ctrl reset");
		rd_chk(REG_STATUS, '1, 32'h0, "status reset");
		rd_chk(REG_TAGS, '1, 32'h0000_FFFF, "tags reset");
		rd_chk(REG_PFLAGS, '1, 32'h0, "pflags reset");
		apb(1'b0, 8'h18, 32'h0, q, e);
		chk("unmapped read", 32'h1, {q[30:0], e});
		apb(1'b1, REG_RESULT, 32'h0000_0007, q, e);
		chk("result write refused", 32'h1, {31'h0, e});
	endtask : t_reset
	task automatic t_stack();
		logic [15:0] fill [3];
		op_t         uo [4];
		logic [2:0]  uk [4];
		fill = '{16'h0000, 16'h5555, 16'hAAAA};
		uo   = '{OP_ADD, OP_STORE_FP, OP_STORE_INT, OP_STORE_BCD};
		uk   = '{3'h1, 3'h1, 3'h2, 3'h3};
		foreach (fill[i])
		begin
			wr(REG_TAGS, {16'h0, fill[i]});
			ia(mk(OP_LOAD_SD, CLS_NORMAL), 3'h1, 16'h0243, 16'h0241);
		end
		foreach (uo[i])
		begin
			wr(REG_TAGS, 32'h0000_FFFF);
			ia(mk(uo[i], CLS_NORMAL), uk[i], 16'h0243, 16'h0041);
		end
	endtask : t_stack
	task automatic t_arith();
		wr(REG_TAGS, 32'h0);
		ia(mk(OP_ADD, CLS_INF, 1'b0, CLS_INF, 1'b1), 3'h1, 16'h41, 16'h41);
		ia(mk(OP_SUB, CLS_INF, 1'b1, CLS_INF, 1'b1), 3'h1, 16'h41, 16'h41);
		ia(mk(OP_MUL, CLS_INF, 1'b0, CLS_ZERO), 3'h1, 16'h41, 16'h41);
		ia(mk(OP_DIV, CLS_ZERO, 1'b0, CLS_ZERO), 3'h1, 16'h41, 16'h41);
		ia(mk(OP_DIV, CLS_INF, 1'b0, CLS_INF), 3'h1, 16'h41, 16'h41);
		ia(mk(OP_ADD, CLS_SNAN), 3'h4, 16'h41, 16'h41);
		ia(mk(OP_MUL, CLS_UNSUP), 3'h1, 16'h41, 16'h41);
		ia(mk(OP_ADD, CLS_QNAN), 3'h7, 16'h41, 16'h40);
		ia(mk(OP_SQRT, CLS_NORMAL, 1'b1), 3'h1, 16'h41, 16'h41);
		ia(mk(OP_SQRT, CLS_ZERO, 1'b1), 3'h7, 16'h41, 16'h40);
		ia(mk(OP_LOG, CLS_NORMAL, 1'b1), 3'h1, 16'h41, 16'h41);
		ia(mk(OP_LOG_P1, CLS_NORMAL, 1'b1, CLS_NORMAL, 1'b0, 1'b0, 1'b1), 3'h1, 16'h41, 16'h41);
		ia(mk(OP_REMAINDER, CLS_NORMAL, 1'b0, CLS_ZERO), 3'h1, 16'h441, 16'h41);
		ia(mk(OP_TRIG, CLS_INF), 3'h1, 16'h441, 16'h41);
		ia(mk(OP_STORE_INT, CLS_NORMAL, 1'b0, CLS_NORMAL, 1'b0, 1'b1), 3'h2, 16'h41, 16'h41);
		ia(mk(OP_STORE_INT, CLS_QNAN), 3'h2, 16'h41, 16'h41);
		ia(mk(OP_STORE_BCD, CLS_NORMAL, 1'b0, CLS_NORMAL, 1'b0, 1'b1), 3'h3, 16'h41, 16'h41);
		ia(mk(OP_STORE_BCD, CLS_INF), 3'h3, 16'h41, 16'h41);
		ia(mk(OP_COMPARE, CLS_QNAN), 3'h7, 16'h4141, 16'h4141);
		ia(mk(OP_UCOMPARE, CLS_QNAN), 3'h7, 16'h41, 16'h40);
		wr(REG_PFLAGS, 32'h0);
		ia(mk(OP_COMPARE_FLAGS, CLS_NORMAL, 1'b0, CLS_SNAN), 3'h7, 16'h41, 16'h41);
		rd_chk(REG_PFLAGS, '1, 32'h0000_0007, "processor flags");
		wr(REG_TAGS, 32'h0000_0003);
		ia(mk(OP_EXCHANGE, CLS_NORMAL), 3'h7, 16'h41, 16'h41);
		rd_chk(REG_TAGS, 32'h0000_FFFF, 32'h0000_0008, "exchange tags");
	endtask : t_arith
	task automatic t_trap();
		int c0;
		c0 = calls;
		wr(REG_CTRL, 32'h0);
		wr(REG_STATUS, 32'h0000_0243);
		wr(REG_TAGS, 32'h0000_FFFF);
		op(mk(OP_ADD, CLS_NORMAL));
		rd_chk(REG_STATUS, 32'h0000_3A43, 32'h0000_0041, "trap status");
		rd_chk(REG_TAGS, 32'h0000_FFFF, 32'h0000_FFFF, "trap tags");
		rd_chk(REG_RESULT, 32'h0000_000F, 32'h0000_000D, "trap result");
		chk("handler calls", c0 + 1, calls);
		wr(REG_CTRL, 32'h1);
		wr(REG_STATUS, 32'h0000_0043);
		wr(REG_TAGS, 32'h0);
		op(mk(OP_ADD, CLS_DENORM));
		rd_chk(REG_STATUS, 32'h0000_3843, 32'h0000_0002, "denormal trap status");
		rd_chk(REG_TAGS, 32'h0000_FFFF, 32'h0, "denormal trap tags");
		chk("denormal handler calls", c0 + 2, calls);
	endtask : t_trap
	task automatic t_denorm();
		int c0;
		c0 = calls;
		wr(REG_CTRL, 32'h3);
		wr(REG_STATUS, 32'h0000_0043);
		wr(REG_TAGS, 32'h0000_FFFF);
		op(mk(OP_LOAD_SD, CLS_DENORM));
		rd_chk(REG_STATUS, 32'h0000_0043, 32'h0000_0002, "load denormal");
		rd_chk(REG_TAGS, 32'h0000_FFFF, 32'h0000_3FFF, "load proceeds");
		wr(REG_STATUS, 32'h0000_0043);
		wr(REG_TAGS, 32'h0000_FFFF);
		op(mk(OP_LOAD_EXT, CLS_DENORM));
		rd_chk(REG_STATUS, 32'h0000_0043, 32'h0, "extended denormal");
		wr(REG_TAGS, 32'h0);
		op(mk(OP_ADD, CLS_DENORM));
		rd_chk(REG_RESULT, 32'h0000_0007, 32'h0, "denormal proceeds");
		op(mk(OP_ADD, CLS_INF, 1'b0, CLS_INF, 1'b1));
		rd_chk(REG_STATUS, 32'h0000_0003, 32'h0000_0003, "flags accumulate");
		chk("masked handler calls", c0, calls);
	endtask : t_denorm
	// ==========================================================
	// main sequence and hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_stack();
		t_arith();
		t_trap();
		t_denorm();
		wrap_up();
	end
endmodule : fpu_exc_unit_tb_top
